/* rtl/mwp_params.svh */
// Constants of the metering waveform and power datapath.
// Assumes inclusion by bare name from rtl/ sources only.
`ifndef MWP_PARAMS_SVH
`define MWP_PARAMS_SVH

// Converter sample timing: one result per 128 master clocks
`define MWP_SAMPLE_DIV      8'd128
// Saturation limits of the converter codes
`define MWP_POS_LIMIT       20'h40000
`define MWP_NEG_LIMIT       20'hC0000
// Gain word scaling shift (divide by 4096)
`define MWP_GAIN_SHIFT      12
// Mode register field positions
`define MWP_MODE_RATE_LO    11
`define MWP_MODE_SRC_LO     13
// Sample-ready enable bit of the interrupt enable register
`define MWP_IE_SMP_BIT      3
// Reset values
`define MWP_GAIN_RST        12'h000
`define MWP_PHASE_RST       8'h00
`define MWP_MODE_RST        16'h0000
// Phase trim legal span
`define MWP_PHASE_MIN       -98
`define MWP_PHASE_MAX       92
// Smoothing filter coefficient shift (about 156 Hz at the sample rate)
`define MWP_WAVEFORM_SMOOTHING_FILTER_SHIFT      5
// Power low-pass coefficient shift
`define MWP_POWER_LOWPASS_FILTER_SHIFT      8

`endif

/* rtl/mwp_pkg.sv */
// Types shared by the metering waveform and power datapath.
// Assumes no surroundings beyond the including modules.
package mwp_pkg;
    // Waveform source selection
    typedef enum logic [1:0] {
        MWP_SRC_POWER = 2'h0,
        MWP_SRC_BOTH  = 2'h1,
        MWP_SRC_CH1   = 2'h2,
        MWP_SRC_CH2   = 2'h3
    } mwp_src_t;
    // Decimation rate selection
    typedef logic [1:0] mwp_rate_t;
endpackage

/* rtl/mwp_delay_line.sv */
// Programmable delay line for the channel 2 time shift.
// Assumes one write per sample enable, synchronous inputs.
`timescale 1ns/100ps
`default_nettype none
module mwp_delay_line #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 256
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // Sample stream
    input  wire logic             smp_en,
    input  wire logic [WIDTH-1:0] din,
    input  wire logic [7:0]       delay,
    output logic      [WIDTH-1:0] dout
);
    // Flip-flop storage, one word per sample
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [7:0]       wr_q;
    logic [7:0]       rd_idx;

    // Read index trails the writer by the requested delay
    assign rd_idx = wr_q - delay;

    // Storage write; cleared at reset so that early reads return zero, not unknowns
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (clk_en && smp_en) begin
            mem_q[wr_q] <= din;
        end
    end

    // Write pointer and registered output
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_q <= 8'h00;
            dout <= '0;
        end else if (clk_en && smp_en) begin
            wr_q <= wr_q + 8'h01;
            dout <= mem_q[rd_idx];
        end
    end
endmodule
`default_nettype wire

/* rtl/mwp_datapath.sv */
// Waveform and active power datapath of the metering device.
// Assumes converter results arrive synchronous to core_clk with a valid strobe.
`timescale 1ns/100ps
`default_nettype none
`include "mwp_params.svh"
// Functional notes
// - Samples are 20-bit signed, at most clock/128
// - Converter codes clamp at 40000h and C0000h
// - Channel 1 scaled by one plus gain/4096
// - Source 10 routes channel 1 to waveform
// - Power keeps running during waveform sampling
// - Four decimated rates from mode bits 11-12
// - Interrupt goes low on each waveform load
// - Sample sign-extended to 24 bits, MSB first
// - Source 01 gives packed 40-bit combined sample
// - Source 11 smooths channel 2 with low-pass
// - Multiplier sees unfiltered channel 2
// - Phase trim 8-bit signed, kept -98..+92; the register loads any value unclamped
// - Channel 2 shifted one sample per trim unit
// - Product low-pass filtered gives active power
// - Power range follows gain word 800h..7FFh
// - No channel phase skew with high-pass off; there is no high-pass, and channel 2 lags channel 1 by 100+trim samples
// - Source 00 loads active power into waveform
module mwp_datapath
#(
    parameter int DLY_DEPTH = 256
) (
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Converter results
    input  wire logic        adc_valid,
    input  wire logic [19:0] adc_ch1,
    input  wire logic [19:0] adc_ch2,
    // Configuration registers
    input  wire logic        cfg_we,
    input  wire logic [11:0] power_gain_word_in,
    input  wire logic [7:0]  phase_trim_in,
    input  wire logic [15:0] mode_in,
    input  wire logic [15:0] irq_enable_in,
    // Register readback
    output logic      [11:0] power_gain_word,
    output logic      [7:0]  phase_trim,
    output logic      [15:0] mode_q,
    output logic      [15:0] irq_enable_q,
    // Waveform to the host
    output logic      [39:0] waveform_sample,
    output logic      [23:0] waveform_byte_view,
    output logic      [23:0] active_power,
    output logic             sample_ready_n,
    input  wire logic        irq_ack
);
    import mwp_pkg::*;

    // Clamp a code to the converter limits
    // Over-ranged inputs pin at the limits rather than wrapping, so a
    // full-scale transient can never flip the sign of the power product
    function automatic logic [19:0] sat20(input logic [19:0] x);
        if ($signed(x) > $signed(`MWP_POS_LIMIT)) begin
            sat20 = `MWP_POS_LIMIT;
        end else if ($signed(x) < $signed(`MWP_NEG_LIMIT)) begin
            sat20 = `MWP_NEG_LIMIT;
        end else begin
            sat20 = x;
        end
    endfunction

    // Sign-extend a 20-bit sample to 24 bits
    // The host reads three whole bytes, so the top nibble copies the sign
    function automatic logic [23:0] sx24(input logic [19:0] x);
        sx24 = {{4{x[19]}}, x};
    endfunction

    // Internal pipeline state
    logic [19:0] ch1_q;          // Clamped channel 1
    logic [19:0] ch2_q;          // Clamped channel 2
    logic [19:0] ch2_dly;        // Time-shifted channel 2
    logic [19:0] ch1_gain_q;     // Gain-trimmed channel 1
    logic        smp_q;          // Sample strobe after clamp
    logic        smp2_q;         // Sample strobe after gain
    logic [31:0] waveform_smoothing_filter_q;         // Smoothing filter state
    logic [39:0] power_lowpass_filter_q;         // Power filter state
    logic [9:0]  dec_cnt_q;      // Decimation counter
    logic        rate_hit;       // Decimation instant
    logic        smp_load;       // Waveform load instant
    logic [31:0] gain_prod;      // Channel 1 times the gain factor
    logic [39:0] pw_prod;        // Instantaneous power
    logic [9:0]  rate_mask;      // Low count bits that must be zero
    mwp_src_t    src;            // Waveform source field

    // Register file: host writes steer the pipeline
    // All four words load together; a partial update would briefly pair a
    // new gain with an old phase trim and skew one power sample
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_gain_word <= `MWP_GAIN_RST;
            phase_trim      <= `MWP_PHASE_RST;
            mode_q          <= `MWP_MODE_RST;
            irq_enable_q    <= 16'h0000;
        end else if (clk_en && cfg_we) begin
            power_gain_word <= power_gain_word_in;
            phase_trim      <= phase_trim_in;
            mode_q          <= mode_in;
            irq_enable_q    <= irq_enable_in;
        end
    end

    // Converter capture with clamping
    // Codes are held between strobes so the later stages see stable values
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ch1_q <= 20'h00000;
            ch2_q <= 20'h00000;
            smp_q <= 1'b0;
        end else if (clk_en) begin
            smp_q <= adc_valid;
            if (adc_valid) begin
                ch1_q <= sat20(adc_ch1);
                ch2_q <= sat20(adc_ch2);
            end
        end
    end

    // Channel 2 time shift; advance is a negative delay around the midpoint
    // The fixed 100-sample offset lets a negative trim act as an advance;
    // the memory depth must exceed 100 plus the largest legal trim
    mwp_delay_line #(
        .WIDTH (20),
        .DEPTH (DLY_DEPTH)
    ) u_dly (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .smp_en   (smp_q),
        .din      (ch2_q),
        .delay    (8'h64 + phase_trim),
        .dout     (ch2_dly)
    );

    // Gain product: ch1 * (4096 + gain) / 4096
    // The factor stays positive for every legal gain word, and the clamped
    // input keeps the product inside 32 bits
    assign gain_prod = $signed(ch1_q) * $signed({1'b0, 13'h1000} + {{2{power_gain_word[11]}}, power_gain_word});

    // Gain stage; channel 1 is delayed to match the delay line output
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ch1_gain_q <= 20'h00000;
            smp2_q     <= 1'b0;
        end else if (clk_en) begin
            smp2_q <= smp_q;
            if (smp_q) begin
                ch1_gain_q <= gain_prod[31:12];
            end
        end
    end

    // Instantaneous power from unfiltered, shifted channel 2
    assign pw_prod = 40'($signed(ch1_gain_q) * $signed(ch2_dly));

    // Power low-pass runs every sample regardless of waveform mode
    // Shift-based coefficient: no multiplier, at the cost of a fixed corner
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_lowpass_filter_q <= 40'h0000000000;
        end else if (clk_en && smp2_q) begin
            power_lowpass_filter_q <= power_lowpass_filter_q + 40'(($signed(pw_prod) - $signed(power_lowpass_filter_q)) >>> `MWP_POWER_LOWPASS_FILTER_SHIFT);
        end
    end

    // Channel 2 smoothing filter, single pole
    // The difference is formed one bit wider: full-scale steps of opposite
    // sign would otherwise wrap and kick the filter the wrong way
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            waveform_smoothing_filter_q <= 32'h00000000;
        end else if (clk_en && smp2_q) begin
            waveform_smoothing_filter_q <= waveform_smoothing_filter_q + 32'(($signed({ch2_dly[19], ch2_dly, 12'h000}) - $signed({waveform_smoothing_filter_q[31], waveform_smoothing_filter_q}))
                                   >>> `MWP_WAVEFORM_SMOOTHING_FILTER_SHIFT);
        end
    end

    // Decimation mask from the rate field
    // A mask on a free-running count keeps every rate on one sample grid,
    // so switching rates needs no counter restart
    assign rate_mask = 10'((10'h001 << mode_q[`MWP_MODE_RATE_LO +: 2]) - 10'h001);
    assign rate_hit  = smp2_q && ((dec_cnt_q & rate_mask) == 10'h000);
    assign src       = mwp_src_t'(mode_q[`MWP_MODE_SRC_LO +: 2]);
    // Load strobe: a decimation instant with the sample-ready enable set
    assign smp_load  = rate_hit && irq_enable_q[`MWP_IE_SMP_BIT];

    // Decimation counter counts samples
    // Wraps freely; only its low bits are ever compared
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dec_cnt_q <= 10'h000;
        end else if (clk_en && smp2_q) begin
            dec_cnt_q <= dec_cnt_q + 10'h001;
        end
    end

    // Waveform register loads only at decimation instants
    // Without the enable nothing loads and nothing signals, so a host that
    // forgot the enable sees a frozen register rather than torn samples
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            waveform_sample    <= 40'h0000000000;
            waveform_byte_view <= 24'h000000;
            active_power       <= 24'h000000;
        end else if (clk_en) begin
            if (smp2_q) begin
                active_power <= power_lowpass_filter_q[39:16];
            end
            if (smp_load) begin
                case (src)
                    MWP_SRC_CH1: begin
                        waveform_sample    <= {16'h0000, sx24(ch1_gain_q)};
                        waveform_byte_view <= sx24(ch1_gain_q);
                    end
                    MWP_SRC_BOTH: begin
                        waveform_sample    <= {ch2_dly[19:16], ch1_gain_q[19:16], ch1_gain_q[15:0], ch2_dly[15:0]};
                        waveform_byte_view <= sx24(ch1_gain_q);
                    end
                    MWP_SRC_CH2: begin
                        waveform_sample    <= {16'h0000, sx24(waveform_smoothing_filter_q[31:12])};
                        waveform_byte_view <= sx24(waveform_smoothing_filter_q[31:12]);
                    end
                    MWP_SRC_POWER: begin
                        waveform_sample    <= {16'h0000, power_lowpass_filter_q[39:16]};
                        waveform_byte_view <= power_lowpass_filter_q[39:16];
                    end
                    default: begin
                        waveform_sample <= waveform_sample;
                    end
                endcase
            end
        end
    end

    // Interrupt: new sample pulls low; set wins over acknowledge
    // An acknowledge that meets a fresh sample is dropped, so no sample is lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_ready_n <= 1'b1;
        end else if (clk_en) begin
            if (smp_load) begin
                sample_ready_n <= 1'b0;
            end else if (irq_ack) begin
                sample_ready_n <= 1'b1;
            end
        end
    end

    // Assertions
    // All but a_clamp and a_dec1 watch the registered outputs the host sees, one
    // edge after the decision; those two check internal signals in the same cycle
    property p_irq_on_sample;
        @(posedge core_clk) disable iff (rst)
        (clk_en && rate_hit && irq_enable_q[`MWP_IE_SMP_BIT]) |=> !sample_ready_n;
    endproperty
    a_irq_on_sample: assert property (p_irq_on_sample) else $error("irq not asserted on sample");

    property p_clamp;
        @(posedge core_clk) disable iff (rst)
        ($signed(ch1_q) <= $signed(`MWP_POS_LIMIT)) && ($signed(ch1_q) >= $signed(`MWP_NEG_LIMIT));
    endproperty
    a_clamp: assert property (p_clamp) else $error("channel 1 out of range");

    property p_hold;
        @(posedge core_clk) disable iff (rst)
        !(clk_en && rate_hit) |=> $stable(waveform_sample);
    endproperty
    a_hold: assert property (p_hold) else $error("waveform changed without sample");

    property p_no_irq_disabled;
        @(posedge core_clk) disable iff (rst)
        (sample_ready_n && !irq_enable_q[`MWP_IE_SMP_BIT]) |=> sample_ready_n;
    endproperty
    a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while disabled");

    property p_sign_ext;
        @(posedge core_clk) disable iff (rst)
        (clk_en && smp_load && src == MWP_SRC_CH1) |=> (waveform_byte_view[23:20] == {4{waveform_byte_view[19]}});
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sample not sign extended");

    property p_power_runs;
        @(posedge core_clk) disable iff (rst)
        (clk_en && smp2_q) |=> (active_power == $past(power_lowpass_filter_q[39:16]));
    endproperty
    a_power_runs: assert property (p_power_runs) else $error("power not updated");

    property p_pack;
        @(posedge core_clk) disable iff (rst)
        (clk_en && rate_hit && irq_enable_q[`MWP_IE_SMP_BIT] && src == MWP_SRC_BOTH)
            |=> waveform_sample[35:32] == $past(ch1_gain_q[19:16]);
    endproperty
    a_pack: assert property (p_pack) else $error("combined pack wrong");

    property p_dec1;
        @(posedge core_clk) disable iff (rst)
        (mode_q[`MWP_MODE_RATE_LO +: 2] == 2'h0 && smp2_q) |-> rate_hit;
    endproperty
    a_dec1: assert property (p_dec1) else $error("rate 0 missed sample");

    property p_ready_hold;
        @(posedge core_clk) disable iff (rst)
        (!sample_ready_n && !irq_ack) |=> !sample_ready_n;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready released without acknowledge");

    property p_power_wave;
        @(posedge core_clk) disable iff (rst)
        (clk_en && smp_load && src == MWP_SRC_POWER) |=> (waveform_sample == {16'h0000, active_power});
    endproperty
    a_power_wave: assert property (p_power_wave) else $error("power not loaded into waveform");

    property p_upper_zero;
        @(posedge core_clk) disable iff (rst)
        (clk_en && smp_load && src != MWP_SRC_BOTH) |=> (waveform_sample[39:24] == 16'h0000);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("single sample upper bits not zero");

    property p_pack_ch2;
        @(posedge core_clk) disable iff (rst)
        (clk_en && smp_load && src == MWP_SRC_BOTH)
            |=> ({waveform_sample[39:36], waveform_sample[15:0]} == $past(ch2_dly));
    endproperty
    a_pack_ch2: assert property (p_pack_ch2) else $error("combined channel 2 fields wrong");

    property p_cfg_load;
        @(posedge core_clk) disable iff (rst)
        (clk_en && cfg_we)
            |=> (phase_trim == $past(phase_trim_in)) && (power_gain_word == $past(power_gain_word_in));
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("configuration not loaded");

    c_ch1:   cover property (@(posedge core_clk) rate_hit && src == MWP_SRC_CH1);
    c_both:  cover property (@(posedge core_clk) rate_hit && src == MWP_SRC_BOTH);
    c_irq:   cover property (@(posedge core_clk) $fell(sample_ready_n));
    c_ch2:   cover property (@(posedge core_clk) smp_load && src == MWP_SRC_CH2);
    c_power: cover property (@(posedge core_clk) smp_load && src == MWP_SRC_POWER);
endmodule
`default_nettype wire

/* dv/mwp_host_model.sv */
// Host microcontroller model that answers the sample-ready line.
// Assumes the device releases sample_ready_n one edge after irq_ack.
`timescale 1ns/100ps
`default_nettype none
module mwp_host_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Device side
    input  wire logic        sample_ready_n,
    input  wire logic [39:0] waveform_sample,
    output logic             irq_ack,
    // Bench side
    input  wire logic [7:0]  ack_delay,
    output logic      [39:0] last_sample,
    output int               smp_count
);
    logic [7:0] wait_q;   // Cycles left before the read completes
    logic       busy_q;   // A sample is being fetched

    // Read the held sample after a chosen delay, then acknowledge once
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_ack     <= 1'b0;
            wait_q      <= 8'h00;
            busy_q      <= 1'b0;
            last_sample <= 40'h0;
            smp_count   <= 0;
        end else if (irq_ack) begin
            // One-cycle ack, then wait for the line to rise again
            irq_ack <= 1'b0;
        end else if (!busy_q && !sample_ready_n) begin
            busy_q <= 1'b1;
            wait_q <= ack_delay;
        end else if (busy_q && wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end else if (busy_q) begin
            // Late read still sees the loaded value since it must hold
            irq_ack     <= 1'b1;
            busy_q      <= 1'b0;
            last_sample <= waveform_sample;
            smp_count   <= smp_count + 1;
        end
    end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench of the waveform and power datapath.
// Assumes the datapath and host model are compiled beforehand.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import mwp_pkg::*;
    // Stimulus and observed signals
    logic        core_clk = 0, rst = 1, clk_en = 1, adc_valid = 0, cfg_we = 0, irq_ack;
    logic [19:0] adc_ch1 = 0, adc_ch2 = 0;
    logic [11:0] gain_in = 0, power_gain_word;
    logic [7:0]  trim_in = 0, phase_trim, ack_delay = 8'h01;
    logic [15:0] mode_in = 0, ie_in = 0, mode_q, irq_enable_q;
    logic [39:0] waveform_sample, last_sample;
    logic [23:0] waveform_byte_view, active_power;
    logic        sample_ready_n;
    int          smp_count, fails = 0, total_checks = 0;

    always #10 core_clk = ~core_clk;

    mwp_datapath i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .adc_valid(adc_valid),
        .adc_ch1(adc_ch1), .adc_ch2(adc_ch2), .cfg_we(cfg_we), .power_gain_word_in(gain_in),
        .phase_trim_in(trim_in), .mode_in(mode_in), .irq_enable_in(ie_in),
        .power_gain_word(power_gain_word), .phase_trim(phase_trim), .mode_q(mode_q),
        .irq_enable_q(irq_enable_q), .waveform_sample(waveform_sample),
        .waveform_byte_view(waveform_byte_view), .active_power(active_power),
        .sample_ready_n(sample_ready_n), .irq_ack(irq_ack));
    mwp_host_model i_host (.core_clk(core_clk), .rst(rst), .sample_ready_n(sample_ready_n),
        .waveform_sample(waveform_sample), .irq_ack(irq_ack), .ack_delay(ack_delay),
        .last_sample(last_sample), .smp_count(smp_count));

    // Compare one value and report a mismatch at once
    task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Mode word: source in bits 14:13, rate in bits 12:11
    function automatic logic [15:0] md(input mwp_src_t s, input logic [1:0] r);
        return {1'b0, s, r, 11'h000};
    endfunction

    // Load all configuration registers in one strobe
    task automatic cfg(input logic [11:0] g, input logic [7:0] p, input logic [15:0] m,
                       input logic [15:0] ie);
        @(posedge core_clk);
        cfg_we <= 1'b1; gain_in <= g; trim_in <= p; mode_in <= m; ie_in <= ie;
        @(posedge core_clk);
        cfg_we <= 1'b0;
    endtask

    // One converter result strobe
    task automatic pulse(input logic [19:0] c1, input logic [19:0] c2);
        @(posedge core_clk);
        adc_valid <= 1'b1; adc_ch1 <= c1; adc_ch2 <= c2;
        @(posedge core_clk);
        adc_valid <= 1'b0;
    endtask

    // Strobe, check the ready line timing, then pad to the 128-cycle spacing
    task automatic load(input logic [19:0] c1, input logic [19:0] c2, input logic irq);
        pulse(c1, c2);
        @(posedge core_clk);
        #1 chk("ready_early", 40'h1, sample_ready_n);
        @(posedge core_clk);
        #1 chk("ready_n", !irq, sample_ready_n);
        repeat (124) @(posedge core_clk);
    endtask

    task automatic t_reset;
        chk("reset_regs", 40'h0, {power_gain_word, phase_trim, mode_q});
        chk("reset_out", 40'h1, {irq_enable_q, active_power[22:0], sample_ready_n});
        chk("reset_wave", 40'h0, waveform_sample);
        $display("test reset done");
    endtask

    // Single channel 1 samples, including over-range codes that clamp
    task automatic t_ch1;
        logic [19:0] vin [4] = '{20'h2851F, 20'hD7AE1, 20'h7FFFF, 20'h80000};
        logic [23:0] vex [4] = '{24'h02851F, 24'hFD7AE1, 24'h040000, 24'hFC0000};
        cfg(12'h000, 8'h9E, md(MWP_SRC_CH1, 2'h0), 16'h0008);
        #1 chk("readback", {4'h0, 12'h000, 8'h9E, md(MWP_SRC_CH1, 2'h0)},
            {power_gain_word, phase_trim, mode_q});
        for (int i = 0; i < 4; i++) begin
            load(vin[i], 20'h00000, 1'b1);
            chk("wave_ch1", {16'h0, vex[i]}, waveform_sample);
            chk("byte_view", vex[i], waveform_byte_view);
            chk("host_read", {16'h0, vex[i]}, last_sample);
        end
        $display("test ch1 done");
    endtask

    // Gain word extremes: 4096 scaled by (4096+gain)/4096
    task automatic t_gain;
        logic [11:0] g [3] = '{12'h7FF, 12'h801, 12'h800};
        logic [23:0] ex [3] = '{24'h0017FF, 24'h000801, 24'h000800};
        for (int i = 0; i < 3; i++) begin
            cfg(g[i], 8'h9E, md(MWP_SRC_CH1, 2'h0), 16'h0008);
            load(20'h01000, 20'h00000, 1'b1);
            chk("gain_scaled", {16'h0, ex[i]}, waveform_sample);
        end
        $display("test gain done");
    endtask

    // Every enable bit but the sample-ready one: nothing loads
    task automatic t_refuse;
        logic [39:0] prev;
        cfg(12'h000, 8'h9E, md(MWP_SRC_CH1, 2'h0), 16'hFFF7);
        #1 chk("ie_readback", 40'hFFF7, irq_enable_q);
        prev = waveform_sample;
        load(20'h12345, 20'h00000, 1'b0);
        chk("wave_held", prev, waveform_sample);
        $display("test refuse done");
    endtask

    // Combined packing and channel 2 delay of 100+trim samples
    task automatic t_both;
        for (int d = 0; d < 2; d++) begin
            cfg(12'h000, 8'(8'h9E + d), md(MWP_SRC_BOTH, 2'h0), 16'h0008);
            for (int k = 0; k < 6; k++) begin
                load(20'hC1234, {4'h1, 16'(k)}, 1'b1);
                if (k >= 2 + d)
                    chk("combined", {4'h1, 4'hC, 16'h1234, 16'(k - 2 - d)}, waveform_sample);
            end
        end
        $display("test both done");
    endtask

    // Smoothed channel 2 lags a step; power keeps tracking positive product
    task automatic t_smooth;
        logic [23:0] ap0;
        cfg(12'h000, 8'h9E, md(MWP_SRC_CH2, 2'h0), 16'h0008);
        ap0 = active_power;
        for (int k = 0; k < 10; k++)
            load(20'h10000, 20'h20000, 1'b1);
        chk("smooth_lag", 40'h1, $signed(waveform_sample[23:0]) > 0
            && $signed(waveform_sample[23:0]) < 24'sh020000);
        chk("power_rises", 40'h1, $signed(active_power) > $signed(ap0));
        $display("test smooth done");
    endtask

    // Power source: the waveform register carries the active power value
    task automatic t_power;
        cfg(12'h000, 8'h9E, md(MWP_SRC_POWER, 2'h0), 16'h0008);
        load(20'h10000, 20'h20000, 1'b1);
        chk("wave_power", {16'h0, active_power}, waveform_sample);
        $display("test power done");
    endtask

    // Eight results per rate code give 8, 4, 2 and 1 interrupts
    task automatic t_rate;
        int n0;
        ack_delay <= 8'd20;
        for (int r = 0; r < 4; r++) begin
            cfg(12'h000, 8'h9E, md(MWP_SRC_CH1, 2'(r)), 16'h0008);
            n0 = smp_count;
            for (int k = 0; k < 8; k++) begin
                pulse(20'h00100, 20'h00100);
                repeat (126) @(posedge core_clk);
            end
            chk("irq_count", 40'(8 >> r), 40'(smp_count - n0));
        end
        $display("test rate done");
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1 t_reset;
        t_ch1;
        t_gain;
        t_refuse;
        t_both;
        t_smooth;
        t_power;
        t_rate;
        finish_test;
    end

    // Watchdog well beyond the roughly 8100 cycles the tests need
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        $display("watchdog expired");
        finish_test;
    end
endmodule
`default_nettype wire
